// file: core/sdmc_core.sv
// Stall detect motion controller core with AXI4-Lite register access
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module sdmc_core #(
    parameter int PROG_DEPTH = 2048,
    parameter int CFG_BYTES = 1024
) (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Sync reset, active low
    input wire logic [7:0] s_awaddr, // Write address
    input wire logic s_awvalid, // Write address valid
    output logic s_awready, // Write address ready
    input wire logic [31:0] s_wdata, // Write data
    input wire logic [3:0] s_wstrb, // Byte strobes
    input wire logic s_wvalid, // Write data valid
    output logic s_wready, // Write data ready
    output logic [1:0] s_bresp, // Write response
    output logic s_bvalid, // Write response valid
    input wire logic s_bready, // Write response ready
    input wire logic [7:0] s_araddr, // Read address
    input wire logic s_arvalid, // Read address valid
    output logic s_arready, // Read address ready
    output logic [31:0] s_rdata, // Read data
    output logic [1:0] s_rresp, // Read response
    output logic s_rvalid, // Read data valid
    input wire logic s_rready, // Read data ready
    input wire logic [7:0] load_value, // Measured motor load
    input wire logic load_update, // New load sample pulse
    input wire logic over_temp, // Driver over temperature
    input wire logic over_current, // Coil over current
    output sdmc_pkg::sdmc_motion_t motion_q, // Parameters to ramp generator
    output logic coil_enable_q, // Coil drive enable
    output logic pos_zero_q, // Position zero pulse
    output logic [15:0] baud_div_q, // Serial baud divisor
    output logic [9:0] can_kbps_q, // CAN bit rate in kbit/s
    output logic [10:0] can_id_q, // CAN node id
    output logic [10:0] coil_ma_q, // Coil current setting
    output logic irq_q // Interrupt, level
);
    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0] thr_q; // Signed stall threshold
    logic [7:0] load_q;
    logic [31:0] pos_q;
    logic [17:0] baud_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic [7:0] param_sel_q;
    logic [10:0] prog_addr_q;
    logic [7:0] cfg_addr_q;
    logic [7:0] cfg_mem [CFG_BYTES];
    sdmc_pkg::sdmc_state_t state_q;
    // Write channel holding
    logic [7:0] aw_q;
    logic aw_full_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    logic w_full_q;
    // Decoded strobes and status
    logic do_wr;
    logic [7:0] thr_mag;
    logic stall_hit;
    logic host_stop;
    logic drv_ok;
    logic [31:0] prog_rdata;
    logic [2:0] ev;

    // Sign extension of an eight-bit register to a bus word
    function automatic logic [31:0] sext8(input logic [7:0] v);
        return {{24{v[7]}}, v};
    endfunction

    // Writes refused: outside the map, misaligned, or to the load and status registers
    function automatic logic wr_err(input logic [7:0] a);
        return a > sdmc_pkg::REG_PROG_DATA || a[1:0] != 2'b00
            || a == sdmc_pkg::REG_LOAD || a == sdmc_pkg::REG_STATUS;
    endfunction

    assign do_wr = aw_full_q && w_full_q && !s_bvalid;
    assign thr_mag = thr_q[7] ? 8'(-thr_q) : thr_q;
    // Compare on each load update while moving with a nonzero threshold
    assign stall_hit = (thr_q != sdmc_pkg::STALL_THR_RST) && load_update
        && (state_q == sdmc_pkg::ST_RUN) && (load_value >= thr_mag);
    assign host_stop = do_wr && ws_q[0] && aw_q == sdmc_pkg::REG_CTRL && !w_q[0];
    assign drv_ok = !over_temp && !over_current;

    ////////////////////////////////////////////////////////////////////////////
    // Write channel capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= sdmc_pkg::AXI_OKAY;
        end else begin
            s_awready <= !aw_full_q && !(s_awvalid && s_awready);
            s_wready <= !w_full_q && !(s_wvalid && s_wready);
            if (s_awvalid && s_awready) begin
                aw_q <= s_awaddr;
                aw_full_q <= 1'b1;
            end
            if (s_wvalid && s_wready) begin
                w_q <= s_wdata;
                ws_q <= s_wstrb;
                w_full_q <= 1'b1;
            end
            if (do_wr) begin
                s_bvalid <= 1'b1;
                s_bresp <= wr_err(aw_q) ? sdmc_pkg::AXI_SLVERR : sdmc_pkg::AXI_OKAY;
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            thr_q <= sdmc_pkg::STALL_THR_RST;
            baud_q <= 18'(sdmc_pkg::BAUD_DEFAULT);
            can_kbps_q <= sdmc_pkg::CAN_KBPS_RST;
            can_id_q <= sdmc_pkg::CAN_ID_RST;
            irq_mask_q <= 3'h0;
            param_sel_q <= 8'h00;
            prog_addr_q <= 11'h000;
            coil_ma_q <= sdmc_pkg::COIL_MA_MAX;
            motion_q <= '0;
        end else if (do_wr && ws_q[0]) begin
            unique case (aw_q)
                sdmc_pkg::REG_CTRL: begin
                    motion_q.run <= w_q[0];
                    motion_q.dir <= w_q[1];
                end
                sdmc_pkg::REG_STALL_THR: thr_q <= w_q[7:0];
                sdmc_pkg::REG_IRQ_MASK: irq_mask_q <= w_q[2:0];
                // Link settings
                sdmc_pkg::REG_BAUD: baud_q <= w_q[17:0];
                sdmc_pkg::REG_CAN: begin
                    can_kbps_q <= (w_q[9:0] > 10'(sdmc_pkg::CAN_RATE_MAX_KBPS))
                        ? 10'(sdmc_pkg::CAN_RATE_MAX_KBPS) : w_q[9:0];
                    can_id_q <= w_q[26:16];
                end
                // Motion and drive settings
                sdmc_pkg::REG_VMAX: motion_q.vmax <= w_q[15:0];
                sdmc_pkg::REG_AMAX: motion_q.amax <= w_q[15:0];
                sdmc_pkg::REG_CURRENT: coil_ma_q <= (w_q[10:0] > sdmc_pkg::COIL_MA_MAX)
                    ? sdmc_pkg::COIL_MA_MAX : w_q[10:0];
                sdmc_pkg::REG_PARAM: begin
                    param_sel_q <= w_q[7:0];
                    if (w_q[7:0] == sdmc_pkg::PAR_STALL_THR && w_q[31]) begin
                        thr_q <= w_q[15:8];
                    end
                end
                sdmc_pkg::REG_PROG_ADDR: prog_addr_q <= w_q[10:0];
                default: ;
            endcase
            // A stall in the same cycle still stops the axis
            if (stall_hit) begin
                motion_q.run <= 1'b0;
            end
        end else if (stall_hit) begin
            motion_q.run <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Axis state, load and position
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= sdmc_pkg::ST_IDLE;
            load_q <= 8'h00;
            pos_q <= 32'h0000_0000;
            pos_zero_q <= 1'b0;
        end else begin
            pos_zero_q <= 1'b0;
            if (load_update) begin
                load_q <= load_value;
            end
            // Position follows each sample while running except a sample that stalls the axis
            if (state_q == sdmc_pkg::ST_RUN && load_update && !stall_hit) begin
                pos_q <= motion_q.dir ? pos_q - 32'h1 : pos_q + 32'h1;
            end
            unique case (state_q)
                sdmc_pkg::ST_IDLE, sdmc_pkg::ST_STALLED: begin
                    if (motion_q.run && !host_stop) begin
                        state_q <= sdmc_pkg::ST_RUN;
                    end
                end
                sdmc_pkg::ST_RUN: begin
                    if (host_stop || !motion_q.run) begin
                        state_q <= sdmc_pkg::ST_IDLE;
                    end else if (stall_hit) begin
                        state_q <= sdmc_pkg::ST_STALLED;
                        if (thr_q[7]) begin
                            pos_q <= 32'h0000_0000;
                            pos_zero_q <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Coil protection and baud divisor
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            coil_enable_q <= 1'b0;
            baud_div_q <= sdmc_pkg::baud_div(18'(sdmc_pkg::BAUD_DEFAULT));
        end else begin
            coil_enable_q <= drv_ok;
            baud_div_q <= sdmc_pkg::baud_div(baud_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Events that raise status bits
    always_comb begin
        ev = 3'h0;
        ev[sdmc_pkg::IRQ_STALL] = stall_hit;
        ev[sdmc_pkg::IRQ_DRV_OFF] = coil_enable_q && !drv_ok;
        ev[sdmc_pkg::IRQ_STOPPED] = host_stop && state_q == sdmc_pkg::ST_RUN;
    end
    // Interrupt status, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= 3'h0;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((do_wr && ws_q[0] && aw_q == sdmc_pkg::REG_IRQ_STAT)
                ? w_q[2:0] : 3'h0)) | ev;
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration byte store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_addr_q <= 8'h00;
        end else if (do_wr && ws_q[0] && aw_q == sdmc_pkg::REG_STALL_THR) begin
            cfg_mem[0] <= w_q[7:0];
        end
    end

    // Stored program words
    sdmc_prog_mem #(.DEPTH(PROG_DEPTH), .WIDTH(32)) i_sdmc_prog_mem (
        .aclk(aclk),
        .we(do_wr && ws_q[0] && aw_q == sdmc_pkg::REG_PROG_DATA),
        .addr(prog_addr_q),
        .wdata(w_q),
        .rdata(prog_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= sdmc_pkg::AXI_OKAY;
        end else begin
            s_arready <= !s_rvalid && !(s_arvalid && s_arready);
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rresp <= sdmc_pkg::AXI_OKAY;
                unique case (s_araddr)
                    // Axis and stall registers
                    sdmc_pkg::REG_CTRL: s_rdata <= {30'h0, motion_q.dir, motion_q.run};
                    sdmc_pkg::REG_STALL_THR: s_rdata <= sext8(thr_q);
                    sdmc_pkg::REG_LOAD: s_rdata <= {24'h0, load_q};
                    sdmc_pkg::REG_STATUS: s_rdata <= {27'h0, drv_ok, coil_enable_q,
                        1'b0, state_q};
                    sdmc_pkg::REG_IRQ_STAT: s_rdata <= {29'h0, irq_stat_q};
                    sdmc_pkg::REG_IRQ_MASK: s_rdata <= {29'h0, irq_mask_q};
                    // Link and drive registers
                    sdmc_pkg::REG_BAUD: s_rdata <= {14'h0, baud_q};
                    sdmc_pkg::REG_CAN: s_rdata <= {5'h0, can_id_q, 6'h0, can_kbps_q};
                    sdmc_pkg::REG_VMAX: s_rdata <= {16'h0, motion_q.vmax};
                    sdmc_pkg::REG_AMAX: s_rdata <= {16'h0, motion_q.amax};
                    sdmc_pkg::REG_POS: s_rdata <= pos_q;
                    sdmc_pkg::REG_CURRENT: s_rdata <= {17'h0, sdmc_pkg::MICROSTEP_LOG2, coil_ma_q};
                    // Parameter window and program store
                    sdmc_pkg::REG_PARAM: s_rdata <= (param_sel_q == sdmc_pkg::PAR_LOAD)
                        ? {24'h0, load_q} : sext8(thr_q);
                    sdmc_pkg::REG_PROG_ADDR: s_rdata <= {21'h0, prog_addr_q};
                    sdmc_pkg::REG_PROG_DATA: s_rdata <= prog_rdata;
                    default: begin
                        s_rdata <= 32'h0000_0000;
                        s_rresp <= sdmc_pkg::AXI_SLVERR;
                    end
                endcase
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end
endmodule // sdmc_core

// file: core/sdmc_pkg.sv
// Package: constants, register map and types of the stall detect motion controller
package sdmc_pkg;
    localparam int unsigned CLK_HZ = 250000000;
    // Axis parameter numbers
    localparam logic [7:0] PAR_STALL_THR = 8'd205;
    localparam logic [7:0] PAR_LOAD = 8'd206;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STALL_THR = 8'h04;
    localparam logic [7:0] REG_LOAD = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK = 8'h14;
    localparam logic [7:0] REG_BAUD = 8'h18;
    localparam logic [7:0] REG_CAN = 8'h1c;
    localparam logic [7:0] REG_VMAX = 8'h20;
    localparam logic [7:0] REG_AMAX = 8'h24;
    localparam logic [7:0] REG_POS = 8'h28;
    localparam logic [7:0] REG_CURRENT = 8'h2c;
    localparam logic [7:0] REG_PARAM = 8'h30;
    localparam logic [7:0] REG_PROG_ADDR = 8'h34;
    localparam logic [7:0] REG_PROG_DATA = 8'h38;
    // Reset values and limits
    localparam logic [7:0] STALL_THR_RST = 8'h00;
    localparam int unsigned BAUD_DEFAULT = 9600;
    localparam int unsigned BAUD_MAX = 115200;
    localparam int unsigned CAN_RATE_MAX_KBPS = 500;
    localparam logic [9:0] CAN_KBPS_RST = 10'd500;
    localparam logic [10:0] CAN_ID_RST = 11'h001;
    localparam int unsigned PROG_DEPTH = 2048;
    localparam int unsigned CFG_BYTES = 1024;
    localparam logic [3:0] MICROSTEP_LOG2 = 4'd4;
    localparam logic [10:0] COIL_MA_MAX = 11'd1500;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    // Interrupt bit positions
    localparam int unsigned IRQ_STALL = 0;
    localparam int unsigned IRQ_DRV_OFF = 1;
    localparam int unsigned IRQ_STOPPED = 2;
    localparam int unsigned IRQ_W = 3;

    // Motion parameters forwarded to the ramp generator
    typedef struct packed {
        logic run;
        logic dir;
        logic [15:0] vmax;
        logic [15:0] amax;
    } sdmc_motion_t;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STALLED} sdmc_state_t;

    // Baud divisor for a given rate, clamped to the documented maximum
    function automatic logic [15:0] baud_div(input logic [17:0] bps);
        logic [31:0] r;
        r = (bps > 18'(BAUD_MAX)) ? BAUD_MAX : ((bps == 18'd0) ? BAUD_DEFAULT : 32'(bps));
        return 16'(CLK_HZ / r);
    endfunction
endpackage

// file: core/sdmc_prog_mem.sv
// Program store memory with registered read data
`timescale 1ns/1ps
module sdmc_prog_mem #(
    parameter int DEPTH = 2048,
    parameter int WIDTH = 32
) (
    input wire logic aclk, // Clock
    input wire logic we, // Write strobe
    input wire logic [$clog2(DEPTH)-1:0] addr, // Word address
    input wire logic [WIDTH-1:0] wdata, // Write data
    output logic [WIDTH-1:0] rdata // Registered read data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Write and registered read
    always_ff @(posedge aclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule // sdmc_prog_mem

// file: tb/sdmc_core_chk.sv
// Port checker for the stall detect motion controller core
`timescale 1ns/1ps
module sdmc_core_chk (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic over_temp, // Fault input
    input wire logic over_current, // Fault input
    input wire logic load_update, // Sample pulse
    input wire logic s_arvalid, // Read address valid
    input wire logic s_arready, // Read address ready
    input wire logic s_rvalid, // Read data valid
    input wire sdmc_pkg::sdmc_motion_t motion_q, // Motion parameters
    input wire logic coil_enable_q, // Coil enable
    input wire logic pos_zero_q, // Position zero pulse
    input wire logic [15:0] baud_div_q, // Baud divisor
    input wire logic [9:0] can_kbps_q, // CAN rate
    input wire logic [10:0] coil_ma_q, // Coil current
    input wire logic irq_q // Interrupt
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    // Coil drive follows the fault inputs
    property p_coil_off; (over_temp || over_current) |=> !coil_enable_q; endproperty
    a_coil_off: assert property (p_coil_off) else $error("coil on during fault");
    property p_coil_on; (!over_temp && !over_current) |=> coil_enable_q; endproperty
    a_coil_on: assert property (p_coil_on) else $error("coil off without fault");
    // Position zeroing is a single pulse caused by a load sample
    property p_zero_pulse; pos_zero_q |=> !pos_zero_q; endproperty
    a_zero_pulse: assert property (p_zero_pulse) else $error("zero pulse too long");
    property p_zero_cause;
        pos_zero_q |-> ($past(load_update) || $past(load_update, 2));
    endproperty
    a_zero_cause: assert property (p_zero_cause) else $error("zero without sample");
    // Read answer one cycle after the address is taken
    property p_r_lat; s_arvalid && s_arready |=> s_rvalid; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    // Configuration outputs stay inside their limits
    property p_baud; baud_div_q >= 16'h087a; endproperty
    a_baud: assert property (p_baud) else $error("baud above maximum");
    property p_can; can_kbps_q <= 10'h1f4; endproperty
    a_can: assert property (p_can) else $error("can rate above maximum");
    property p_coil_ma; coil_ma_q <= 11'h5dc; endproperty
    a_coil_ma: assert property (p_coil_ma) else $error("coil current above maximum");
    // Main scenarios
    c_zero: cover property (pos_zero_q);
    c_irq: cover property ($rose(irq_q));
    c_coil: cover property ($fell(coil_enable_q));
endmodule // sdmc_core_chk
bind sdmc_core sdmc_core_chk i_sdmc_core_chk (.aclk(aclk), .aresetn(aresetn),
    .over_temp(over_temp), .over_current(over_current), .load_update(load_update),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
    .motion_q(motion_q), .coil_enable_q(coil_enable_q), .pos_zero_q(pos_zero_q),
    .baud_div_q(baud_div_q), .can_kbps_q(can_kbps_q), .coil_ma_q(coil_ma_q), .irq_q(irq_q));

// file: tb/sdmc_sens_model.sv
// Load sensor and driver fault model facing the core
`timescale 1ns/1ps
module sdmc_sens_model (
    input wire logic aclk, // Clock
    output logic [7:0] load_value, // Load sample
    output logic load_update, // Sample pulse
    output logic over_temp, // Over temperature
    output logic over_current // Over current
);
    ////////////////////////////////////////////////////////////////////////////////
    // Idle levels at time zero
    initial begin
        load_value = 8'h00;
        load_update = 1'b0;
        over_temp = 1'b0;
        over_current = 1'b0;
    end
    // One load sample, pulse for one cycle, value kept as current load
    task automatic sample(input logic [7:0] v);
        @(posedge aclk);
        load_value <= v;
        load_update <= 1'b1;
        @(posedge aclk);
        load_update <= 1'b0;
    endtask
    // Fault levels of the driver
    task automatic fault(input logic t, input logic c);
        @(posedge aclk);
        over_temp <= t;
        over_current <= c;
    endtask
endmodule // sdmc_sens_model

// file: tb/test_stall_detect_motion_ctrl.sv
// Self-checking testbench for the stall detect motion controller core
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module test_stall_detect_motion_ctrl;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00, load_value;
    logic [31:0] s_wdata = 32'h0, s_rdata, rdat;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, load_update, over_temp;
    logic over_current, coil_enable_q, pos_zero_q, irq_q;
    logic [1:0] s_bresp, s_rresp, bresp_v, rresp_v;
    logic [15:0] baud_div_q;
    logic [9:0] can_kbps_q;
    logic [10:0] can_id_q, coil_ma_q;
    sdmc_pkg::sdmc_motion_t motion_q;
    int err_total = 0, num_checks = 0, zcnt = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Design and sensor model
    sdmc_core i_sdmc_core (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf),
        .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .load_value(load_value), .load_update(load_update),
        .over_temp(over_temp), .over_current(over_current), .motion_q(motion_q),
        .coil_enable_q(coil_enable_q), .pos_zero_q(pos_zero_q), .baud_div_q(baud_div_q),
        .can_kbps_q(can_kbps_q), .can_id_q(can_id_q), .coil_ma_q(coil_ma_q), .irq_q(irq_q));
    sdmc_sens_model i_sdmc_sens_model (.aclk(aclk), .load_value(load_value),
        .load_update(load_update), .over_temp(over_temp), .over_current(over_current));
    // Clock and zero pulse counter
    always #2 aclk = ~aclk;
    always @(posedge aclk) if (pos_zero_q === 1'b1) zcnt <= zcnt + 1;
    ////////////////////////////////////////////////////////////////////////////////
    // Bus write, address and data offered together
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
            if (s_bvalid) begin
                bresp_v = s_bresp;
                break;
            end
        end
        s_bready <= 1'b0;
    endtask
    // Bus read
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
            if (s_rvalid) begin
                rdat = s_rdata;
                rresp_v = s_rresp;
                break;
            end
        end
        s_rready <= 1'b0;
    endtask
    task automatic settle();
        repeat (3) @(posedge aclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        rd(8'h04);
        `CHK("thr reset", 8'h00, rdat[7:0])
        `CHK("baud reset", 16'h65b9, baud_div_q)
        `CHK("can reset", 10'h1f4, can_kbps_q)
        `CHK("coil ma reset", 11'h5dc, coil_ma_q)
        `CHK("coil on", 1'b1, coil_enable_q)
        $display("test reset done");
    endtask
    task automatic t_config();
        w(8'h18, 32'd115200);
        settle();
        `CHK("baud max", 16'h087a, baud_div_q)
        w(8'h18, 32'd200000);
        settle();
        `CHK("baud clamp", 16'h087a, baud_div_q)
        w(8'h1c, {5'h00, 11'h005, 6'h00, 10'h320});
        `CHK("can clamp", 10'h1f4, can_kbps_q)
        `CHK("can id", 11'h005, can_id_q)
        w(8'h2c, 32'd2000);
        `CHK("coil clamp", 11'h5dc, coil_ma_q)
        rd(8'h2c);
        `CHK("microstep", 4'h4, rdat[14:11])
        w(8'h20, 32'h1234);
        w(8'h24, 32'h0056);
        `CHK("vmax", 16'h1234, motion_q.vmax)
        `CHK("amax", 16'h0056, motion_q.amax)
        $display("test config done");
    endtask
    task automatic t_stall(input logic [7:0] thr, input logic [7:0] hit, input int zexp);
        w(8'h14, 32'h7);
        w(8'h30, {16'h8000, thr, 8'hcd});
        rd(8'h04);
        `CHK("thr set", thr, rdat[7:0])
        w(8'h00, 32'h1);
        i_sdmc_sens_model.sample(hit - 8'h01);
        i_sdmc_sens_model.sample(hit - 8'h01);
        settle();
        `CHK("run below", 1'b1, motion_q.run)
        i_sdmc_sens_model.sample(hit);
        settle();
        `CHK("run stalled", 1'b0, motion_q.run)
        `CHK("zero count", zexp, zcnt)
        rd(8'h28);
        `CHK("pos zeroed", thr[7], rdat == 32'h0)
        rd(8'h0c);
        `CHK("state", 2'h2, rdat[1:0])
        w(8'h30, 32'h0000_00ce);
        rd(8'h30);
        `CHK("load read", hit, rdat[7:0])
        `CHK("irq stall", 1'b1, irq_q)
        w(8'h10, 32'h1);
        settle();
        `CHK("irq clear", 1'b0, irq_q)
        $display("test stall done");
    endtask
    task automatic t_others();
        w(8'h04, 32'h0);
        w(8'h00, 32'h3);
        i_sdmc_sens_model.sample(8'hff);
        settle();
        `CHK("run no stall", 1'b1, motion_q.run)
        `CHK("dir", 1'b1, motion_q.dir)
        w(8'h14, 32'h0);
        w(8'h00, 32'h0);
        `CHK("host stop", 1'b0, motion_q.run)
        rd(8'h10);
        `CHK("stop flag", 1'b1, rdat[2])
        `CHK("irq masked", 1'b0, irq_q)
        w(8'h14, 32'h4);
        settle();
        `CHK("irq unmasked", 1'b1, irq_q)
        i_sdmc_sens_model.fault(1'b1, 1'b0);
        settle();
        `CHK("temp off", 1'b0, coil_enable_q)
        i_sdmc_sens_model.fault(1'b0, 1'b1);
        settle();
        `CHK("current off", 1'b0, coil_enable_q)
        i_sdmc_sens_model.fault(1'b0, 1'b0);
        settle();
        `CHK("coil back", 1'b1, coil_enable_q)
        rd(8'h10);
        `CHK("drv flag", 1'b1, rdat[1])
        w(8'h08, 32'h1);
        `CHK("load ro", 2'b10, bresp_v)
        rd(8'h3c);
        `CHK("unmapped", 34'h2_0000_0000, {rresp_v, rdat})
        w(8'h34, 32'd2047);
        w(8'h38, 32'hcafe_0123);
        w(8'h34, 32'd0);
        w(8'h38, 32'h0000_005a);
        w(8'h34, 32'd2047);
        rd(8'h38);
        `CHK("prog top", 32'hcafe_0123, rdat)
        $display("test others done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200us;
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_config();
        t_stall(8'hb9, 8'h47, 1);
        t_stall(8'h11, 8'h11, 1);
        t_others();
        report_and_stop();
    end
endmodule // test_stall_detect_motion_ctrl
